/* core/txhbs_map.svh */
`ifndef TXHBS_MAP_SVH
`define TXHBS_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TXHBS_CTRL_ADDR 12'h150
`define TXHBS_SEL_ADDR 12'h154
`define TXHBS_STAT_ADDR 12'h158
// ----------------------------------------
// field positions
// ----------------------------------------
`define TXHBS_PICK_BIT 7
`define TXHBS_STYLE_BIT 0
`define TXHBS_CKSUM_BIT 1
`define TXHBS_HALT_BIT 2
`define TXHBS_BUSY_BIT 0
`define TXHBS_DONE_BIT 1
`define TXHBS_ACT_BIT 2
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define TXHBS_SEL_RST 8'h00
`define TXHBS_CTRL_RST 3'h0
`define TXHBS_BOS_LEN 7'h02
`define TXHBS_FCS_INIT 16'hFFFF
`define TXHBS_FCS_POLY 16'h8408
`endif

/* core/txhbs_pkg.sv */
package txhbs_pkg;
   // register image of the select and length register
   typedef struct packed {
      logic tx_buffer_pick;
      logic [6:0] tx_message_length_count;
   } txhbs_sel_t;
   // read request toward the message buffers
   typedef struct packed {
      logic req;
      logic buf_sel;
      logic [6:0] addr;
   } txhbs_rdreq_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RD = 5'h02,
      ST_LOAD = 5'h04,
      ST_PUSH = 5'h08,
      ST_FCS = 5'h10
   } txhbs_state_t;
endpackage

/* core/txhbs_fifo.sv */
`timescale 1ns/1ps
// two-entry octet buffer; head slot feeds the output directly
module txhbs_fifo (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   logic [7:0] slot_q [0:1];
   logic [7:0] slot_d [0:1];
   logic [1:0] full_q;
   logic [1:0] full_d;
   logic pop;
   logic push;

   always_comb begin
      pop = full_q[0] & out_ready;
      push = in_valid & ~full_q[1];
      slot_d[0] = slot_q[0];
      slot_d[1] = slot_q[1];
      full_d = full_q;
      if (pop) begin
         slot_d[0] = slot_q[1];
         full_d = {1'b0, full_q[1]};
      end
      if (push) begin
         if (!full_d[0]) begin
            slot_d[0] = in_data;
            full_d[0] = 1'b1;
         end else begin
            slot_d[1] = in_data;
            full_d[1] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         full_q <= 2'h0;
         slot_q[0] <= 8'h00;
         slot_q[1] <= 8'h00;
      end else begin
         full_q <= full_d;
         slot_q[0] <= slot_d[0];
         slot_q[1] <= slot_d[1];
      end
   end

   // ready only from the second slot, so a stall downstream never drops an octet
   assign in_ready = ~full_q[1];
   assign out_valid = full_q[0];
   assign out_data = slot_q[0];
endmodule

/* core/txhbs_top.sv */
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "txhbs_map.svh"
module txhbs_top (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // message buffer read port, data taken in the same cycle as the request
   output txhbs_pkg::txhbs_rdreq_t BUF_RD_O,
   input wire logic [7:0] BUF_RD_DATA,
   // outbound octet stream
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic [7:0] TX_DATA,
   // event
   output logic TX_TRANSFER_DONE_IRQ
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   txhbs_pkg::txhbs_sel_t sel_q, sel_d;
   txhbs_pkg::txhbs_state_t st_q, st_d;
   txhbs_pkg::txhbs_rdreq_t rd_q, rd_d;
   logic [2:0] ctrl_q, ctrl_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic act_q, act_d;
   logic msg_q, msg_d;
   logic cksum_q, cksum_d;
   logic fcs_hi_q, fcs_hi_d;
   logic [6:0] idx_q, idx_d;
   logic [6:0] rep_q, rep_d;
   logic [7:0] byte_q, byte_d;
   logic [15:0] crc_q, crc_d;
   logic irq_q, irq_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic acc, wr_ctrl, wr_sel, wr_stat;
   logic hit_ctrl, hit_sel, hit_stat;
   logic fifo_in_valid, fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic [6:0] last_idx;
   logic next_free;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ `TXHBS_FCS_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   always_comb begin
      acc = WB_CYC_I & WB_STB_I & ~ack_q;
      hit_ctrl = {WB_ADR_I[11:2], 2'b00} == `TXHBS_CTRL_ADDR;
      hit_sel = {WB_ADR_I[11:2], 2'b00} == `TXHBS_SEL_ADDR;
      hit_stat = {WB_ADR_I[11:2], 2'b00} == `TXHBS_STAT_ADDR;
      wr_ctrl = acc & WB_WE_I & WB_SEL_I[0] & hit_ctrl;
      wr_sel = acc & WB_WE_I & WB_SEL_I[0] & hit_sel;
      wr_stat = acc & WB_WE_I & WB_SEL_I[0] & hit_stat;
      // the buffer in use is never offered to software
      next_free = busy_q ? ~act_q : act_q;
      fifo_in_valid = (st_q == txhbs_pkg::ST_PUSH) | (st_q == txhbs_pkg::ST_FCS);
      if (st_q == txhbs_pkg::ST_FCS) begin
         fifo_in_data = fcs_hi_q ? ~crc_q[15:8] : ~crc_q[7:0];
      end else begin
         fifo_in_data = byte_q;
      end
      last_idx = msg_q ? sel_q.tx_message_length_count - 7'h01 : `TXHBS_BOS_LEN - 7'h01;
   end

   // ----------------------------------------
   // register file and transmit sequencer
   // ----------------------------------------
   always_comb begin
      sel_d = sel_q;
      st_d = st_q;
      rd_d = rd_q;
      ctrl_d = ctrl_q;
      busy_d = busy_q;
      act_d = act_q;
      msg_d = msg_q;
      cksum_d = cksum_q;
      fcs_hi_d = fcs_hi_q;
      idx_d = idx_q;
      rep_d = rep_q;
      byte_d = byte_q;
      crc_d = crc_q;
      irq_d = 1'b0;
      done_d = done_q;
      ack_d = acc;
      dat_d = 32'h0000_0000;
      rd_d.req = 1'b0;
      if (acc & ~WB_WE_I) begin
         if (hit_ctrl) begin
            dat_d = {29'h0000_0000, ctrl_q};
         end else if (hit_sel) begin
            dat_d = {24'h00_0000, next_free, sel_q.tx_message_length_count};
         end else if (hit_stat) begin
            dat_d = {29'h0000_0000, act_q, done_q, busy_q};
         end
      end
      if (wr_ctrl) begin
         ctrl_d = WB_DAT_I[2:0];
      end
      if (wr_stat & WB_DAT_I[`TXHBS_DONE_BIT]) begin
         done_d = 1'b0;
      end
      case (st_q)
         txhbs_pkg::ST_RD: begin
            rd_d.req = 1'b1;
            rd_d.addr = idx_q;
            st_d = txhbs_pkg::ST_LOAD;
         end
         txhbs_pkg::ST_LOAD: begin
            byte_d = BUF_RD_DATA;
            st_d = txhbs_pkg::ST_PUSH;
         end
         txhbs_pkg::ST_PUSH: begin
            if (fifo_in_ready) begin
               crc_d = crc_step(crc_q, byte_q);
               idx_d = idx_q + 7'h01;
               st_d = txhbs_pkg::ST_RD;
               if (idx_q == last_idx) begin
                  idx_d = 7'h00;
                  if (msg_q) begin
                     if (cksum_q) begin
                        st_d = txhbs_pkg::ST_FCS;
                     end else begin
                        st_d = txhbs_pkg::ST_IDLE;
                        busy_d = 1'b0;
                        irq_d = 1'b1;
                     end
                  end else if (rep_q == 7'h01) begin
                     st_d = txhbs_pkg::ST_IDLE;
                     busy_d = 1'b0;
                     irq_d = 1'b1;
                  end else if (rep_q != 7'h00) begin
                     rep_d = rep_q - 7'h01;
                  end
                  // a zero count never reaches the stop branch above
               end
            end
         end
         txhbs_pkg::ST_FCS: begin
            if (fifo_in_ready) begin
               fcs_hi_d = 1'b1;
               if (fcs_hi_q) begin
                  fcs_hi_d = 1'b0;
                  st_d = txhbs_pkg::ST_IDLE;
                  busy_d = 1'b0;
                  irq_d = 1'b1;
               end
            end
         end
         default: begin
            st_d = txhbs_pkg::ST_IDLE;
         end
      endcase
      if (wr_sel) begin
         // a write starts a fresh transfer from the picked buffer
         sel_d = WB_DAT_I[7:0];
         act_d = WB_DAT_I[`TXHBS_PICK_BIT];
         rd_d.buf_sel = WB_DAT_I[`TXHBS_PICK_BIT];
         msg_d = ctrl_q[`TXHBS_STYLE_BIT];
         cksum_d = ctrl_q[`TXHBS_CKSUM_BIT] & ctrl_q[`TXHBS_STYLE_BIT];
         rep_d = WB_DAT_I[6:0];
         idx_d = 7'h00;
         fcs_hi_d = 1'b0;
         crc_d = `TXHBS_FCS_INIT;
         busy_d = 1'b1;
         st_d = txhbs_pkg::ST_RD;
         // a zero-length message sends nothing and ends at once
         if (ctrl_q[`TXHBS_STYLE_BIT] & (WB_DAT_I[6:0] == 7'h00)) begin
            busy_d = 1'b0;
            irq_d = 1'b1;
            st_d = txhbs_pkg::ST_IDLE;
         end
      end
      if (ctrl_d[`TXHBS_HALT_BIT]) begin
         // halt, reset or a new select write ends an endless repeat
         st_d = txhbs_pkg::ST_IDLE;
         busy_d = 1'b0;
         rd_d.req = 1'b0;
      end
      // set wins over a same-cycle clear
      if (irq_d) begin
         done_d = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sel_q <= `TXHBS_SEL_RST;
         st_q <= txhbs_pkg::ST_IDLE;
         rd_q <= '0;
         ctrl_q <= `TXHBS_CTRL_RST;
         busy_q <= 1'b0;
         act_q <= 1'b0;
         msg_q <= 1'b0;
         cksum_q <= 1'b0;
         fcs_hi_q <= 1'b0;
         idx_q <= 7'h00;
         rep_q <= 7'h00;
         byte_q <= 8'h00;
         crc_q <= `TXHBS_FCS_INIT;
         irq_q <= 1'b0;
         done_q <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         sel_q <= sel_d;
         st_q <= st_d;
         rd_q <= rd_d;
         ctrl_q <= ctrl_d;
         busy_q <= busy_d;
         act_q <= act_d;
         msg_q <= msg_d;
         cksum_q <= cksum_d;
         fcs_hi_q <= fcs_hi_d;
         idx_q <= idx_d;
         rep_q <= rep_d;
         byte_q <= byte_d;
         crc_q <= crc_d;
         irq_q <= irq_d;
         done_q <= done_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // ----------------------------------------
   // output buffer
   // ----------------------------------------
   txhbs_fifo u_fifo (
      .clk(SYS_CLK),
      .rst(RESET),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(TX_VALID),
      .out_ready(TX_READY),
      .out_data(TX_DATA)
   );

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign BUF_RD_O = rd_q;
   assign TX_TRANSFER_DONE_IRQ = irq_q;
endmodule

/* tb/txhbs_chk.sv */
`timescale 1ns/1ps
// ----
// port protocol checks
// ----
module txhbs_chk (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // wishbone
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // buffer port and stream
   input wire txhbs_pkg::txhbs_rdreq_t BUF_RD_O,
   input wire logic [7:0] BUF_RD_DATA,
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_TRANSFER_DONE_IRQ
);
   logic take;
   logic wr_pick;
   logic pick_q;
   assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr_pick = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 12'h154;
   // remembers the written pick for the fetch check
   always_ff @(posedge SYS_CLK) begin
      if (wr_pick) begin
         pick_q <= WB_DAT_I[7];
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   a_ack_next: assert property (take |=> WB_ACK_O) else $error("ack late");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   a_idle_data: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
   a_hole_zero: assert property (WB_ACK_O && !WB_WE_I && !(WB_ADR_I[11:4] == 8'h15 && WB_ADR_I[3:2] != 2'h3)
      |-> WB_DAT_O == 32'h0) else $error("unmapped read nonzero");
   a_pick_fetch: assert property (wr_pick && WB_DAT_I[6:0] != 7'h00 |=> ##[0:2]
      (BUF_RD_O.req && BUF_RD_O.buf_sel == pick_q)) else $error("wrong buffer fetched");
   a_req_space: assert property (BUF_RD_O.req |=> !BUF_RD_O.req [*2]) else $error("reads too close");
   a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("octet dropped");
   a_irq_pulse: assert property (TX_TRANSFER_DONE_IRQ |=> !TX_TRANSFER_DONE_IRQ) else $error("irq held");
   a_rst_quiet: assert property ($past(RESET) |-> !WB_ACK_O && !TX_VALID && !TX_TRANSFER_DONE_IRQ)
      else $error("busy after reset");
endmodule

/* tb/txhbs_far.sv */
`timescale 1ns/1ps
// ----
// message buffers and octet receiver
// ----
module txhbs_far (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // buffer read port
   input wire txhbs_pkg::txhbs_rdreq_t rd_req,
   output logic [7:0] rd_data,
   // receiver
   output logic tx_ready,
   input wire logic slow
);
   logic [1:0] ph_q;
   always_ff @(posedge clk) begin
      ph_q <= rst ? 2'h0 : ph_q + 2'h1;
   end
   // octet stands while req does, the load state takes it then; off it show the inverse, never a stale octet
   assign rd_data = rd_req.req ? {rd_req.buf_sel, rd_req.addr} : ~{rd_req.buf_sel, rd_req.addr};
   // slow receiver takes one octet in four cycles
   assign tx_ready = !slow || ph_q == 2'h3;
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "txhbs_map.svh"
module tb;
   typedef struct {logic [7:0] ctrl; logic [7:0] sel; logic slow; logic [7:0] n;} txhbs_row_t;
   txhbs_row_t rows[6] = '{'{8'h00, 8'h01, 1'b0, 8'd2}, '{8'h00, 8'h83, 1'b1, 8'd6}, '{8'h01, 8'h05, 1'b0, 8'd5},
      '{8'h03, 8'h84, 1'b1, 8'd6}, '{8'h03, 8'h7F, 1'b0, 8'd129}, '{8'h01, 8'h80, 1'b0, 8'd0}};
   logic SYS_CLK = 0;
   logic RESET = 1;
   logic cyc = 0;
   logic stb = 0;
   logic wen = 0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic slow = 0;
   logic tx_ready;
   logic tx_valid;
   logic irq;
   logic [7:0] tx_data;
   logic [7:0] bdat;
   logic [7:0] rd;
   logic [15:0] c;
   txhbs_pkg::txhbs_rdreq_t rdreq;
   logic [7:0] got[$];
   logic [7:0] exp_q[$];
   int error_cnt = 0;
   int n_tests = 0;
   int irq_n = 0;
   int cyc_n = 0;
   int n0;
   always #2 SYS_CLK = ~SYS_CLK;
   txhbs_top txhbs_top_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wen),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BUF_RD_O(rdreq),
      .BUF_RD_DATA(bdat), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_TRANSFER_DONE_IRQ(irq));
   txhbs_far txhbs_far_inst (.clk(SYS_CLK), .rst(RESET), .rd_req(rdreq), .rd_data(bdat), .tx_ready(tx_ready),
      .slow(slow));
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge SYS_CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= we;
      adr <= a;
      sel <= s;
      wdat <= {24'h0, d};
      do @(posedge SYS_CLK); while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic [15:0] crc_up(input logic [15:0] v, input logic [7:0] d);
      v = v ^ {8'h00, d};
      for (int k = 0; k < 8; k++) v = v[0] ? (v >> 1) ^ 16'h8408 : v >> 1;
      return v;
   endfunction
   // stream capture, irq count and watchdog
   always @(posedge SYS_CLK) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
      if (irq === 1'b1) irq_n++;
      cyc_n++;
      if (cyc_n == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge SYS_CLK);
      RESET <= 1'b0;
      wb(0, 12'h154, 8'h00, 4'hF);
      chk("sel reset", rd, 8'h00);
      for (int i = 0; i < 6; i++) begin
         slow <= rows[i].slow;
         wb(1, 12'h150, rows[i].ctrl, 4'h1);
         got.delete();
         n0 = irq_n;
         // previous transfer is over, so either buffer may be picked
         wb(1, 12'h154, rows[i].sel, 4'h1);
         while (irq_n == n0) @(posedge SYS_CLK);
         repeat (20) @(posedge SYS_CLK);
         chk("irq once", irq_n - n0, 1);
         exp_q.delete();
         c = 16'hFFFF;
         if (!rows[i].ctrl[0]) begin
            for (int r = 0; r < rows[i].sel[6:0]; r++) for (int k = 0; k < `TXHBS_BOS_LEN; k++)
               exp_q.push_back({rows[i].sel[7], k[6:0]});
         end else begin
            for (int k = 0; k < rows[i].sel[6:0]; k++) begin
               exp_q.push_back({rows[i].sel[7], k[6:0]});
               c = crc_up(c, {rows[i].sel[7], k[6:0]});
            end
            if (rows[i].ctrl[1]) begin
               exp_q.push_back(~c[7:0]);
               exp_q.push_back(~c[15:8]);
            end
         end
         chk("octet count", got.size(), rows[i].n);
         foreach (got[k]) chk("octet", got[k], exp_q[k]);
         wb(0, 12'h154, 8'h00, 4'hF);
         chk("pick idle", rd, rows[i].sel);
         wb(0, 12'h158, 8'h00, 4'hF);
         chk("status", rd, {5'h00, rows[i].sel[7], 2'b10});
      end
      // endless repeat, then pick and status read while it runs
      wb(1, 12'h150, 8'h00, 4'h1);
      got.delete();
      n0 = irq_n;
      wb(1, 12'h154, 8'h80, 4'h1);
      repeat (300) @(posedge SYS_CLK);
      chk("endless irq", irq_n, n0);
      chk("endless run", got.size() > 40, 1);
      wb(0, 12'h154, 8'h00, 4'hF);
      chk("pick busy", rd, 8'h00);
      wb(0, 12'h158, 8'h00, 4'hF);
      chk("status busy", rd, 8'h07);
      // halt ends the endless repeat, then the sticky done is cleared by writing one
      wb(1, 12'h150, 8'h04, 4'h1);
      repeat (10) @(posedge SYS_CLK);
      n0 = got.size();
      repeat (20) @(posedge SYS_CLK);
      chk("halt stops", got.size(), n0);
      wb(0, 12'h154, 8'h00, 4'hF);
      chk("pick halted", rd, 8'h80);
      wb(1, 12'h158, 8'h02, 4'h1);
      wb(0, 12'h158, 8'h00, 4'hF);
      chk("done cleared", rd, 8'h04);
      // restart an endless repeat so the reset lands mid-transfer
      wb(1, 12'h150, 8'h00, 4'h1);
      wb(1, 12'h154, 8'h00, 4'h1);
      repeat (20) @(posedge SYS_CLK);
      RESET <= 1'b1;
      repeat (3) @(posedge SYS_CLK);
      RESET <= 1'b0;
      wb(0, 12'h200, 8'h00, 4'hF);
      chk("unmapped", rd, 8'h00);
      wb(1, 12'h154, 8'h81, 4'h0);
      wb(0, 12'h154, 8'h00, 4'hF);
      chk("sel ignored", rd, 8'h00);
      tally_and_finish();
   end
endmodule
bind txhbs_top txhbs_chk txhbs_chk_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUF_RD_O(BUF_RD_O), .BUF_RD_DATA(BUF_RD_DATA), .TX_VALID(TX_VALID),
   .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_TRANSFER_DONE_IRQ(TX_TRANSFER_DONE_IRQ));
